// File: design/ret_exec.sv
// Summary of operation
// - Reset opcode resets core state like master clear; AXI4-Lite channel state is kept
// - Return-from-interrupt decoded, low bit selects restore
// - Return-from-interrupt pops stack into program counter
// - Return-from-interrupt sets one global enable at Q4
// - Selector set restores work, status, bank shadows
// - Returns never touch program counter latches
// - Return-with-literal decoded from fixed upper byte
// - Literal written to work register at pop
// - Return-with-literal pops stack into program counter
`timescale 1ns/1ps
`default_nettype none
module ret_exec #(
   parameter int PC_W = 21
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   // Instruction fetch side
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr_word,
   input wire logic [PC_W-1:0] i_stack_top_value,
   output logic o_stack_pop,
   input wire logic i_prio_en,
   input wire logic i_in_high_prio,
   input wire logic i_shadow_save,
   // Core state
   output ret_exec_pkg::phase_t o_phase,
   output logic o_soft_reset,
   output logic [PC_W-1:0] o_pc,
   output logic [7:0] o_work_reg,
   output logic [7:0] o_status,
   output logic [7:0] o_bank_select_reg,
   output logic o_high_prio_global_irq_en,
   output logic o_low_prio_global_irq_en,
   // AXI4-Lite slave
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);
   import ret_exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   phase_t phase_ff;
   op_t op_ff;
   op_t dec_op;
   logic dec_sel;
   logic [7:0] dec_lit;
   logic sel_ff, flush_ff, soft_rst_ff;
   logic [7:0] lit_ff;
   logic [PC_W-1:0] pc_ff;
   logic [7:0] work_ff, status_ff, bank_ff, work_sh_ff, status_sh_ff, bank_sh_ff;
   logic en_high_ff, en_low_ff;
   logic [7:0] latch_hi_ff;
   logic [4:0] latch_up_ff;
   logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;

   ret_exec_decoder u_decoder (
      .i_word(i_instr_word),
      .o_op(dec_op),
      .o_shadow_sel(dec_sel),
      .o_literal(dec_lit)
   );

   ////////////////////////////////////////////////////////////////////////
   // Sequencing terms
   wire rst_all = i_srst | soft_rst_ff;
   wire is_q1 = (phase_ff == PH_Q1);
   wire is_q4 = (phase_ff == PH_Q4);
   wire is_ret = (op_ff == OP_RET_IRQ) || (op_ff == OP_RET_LIT);
   wire pop_now = is_q4 & is_ret;
   wire ret_irq_q4 = is_q4 & (op_ff == OP_RET_IRQ);
   wire ret_lit_q4 = is_q4 & (op_ff == OP_RET_LIT);
   wire restore = ret_irq_q4 & sel_ff;
   wire set_en_low = ret_irq_q4 & i_prio_en & ~i_in_high_prio;
   wire set_en_high = ret_irq_q4 & ~set_en_low;
   wire start_reset = (phase_ff == PH_Q2) & (op_ff == OP_SOFT_RESET);

   // Register write decode
   wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
   wire wr_lo = wr_fire & wstrb_ff[0];
   wire wr_work = wr_lo & (awaddr_ff == ADDR_WORK);
   wire wr_status = wr_lo & (awaddr_ff == ADDR_STATUS);
   wire wr_bank = wr_lo & (awaddr_ff == ADDR_BANK);
   wire wr_work_sh = wr_lo & (awaddr_ff == ADDR_WORK_SH);
   wire wr_status_sh = wr_lo & (awaddr_ff == ADDR_STATUS_SH);
   wire wr_bank_sh = wr_lo & (awaddr_ff == ADDR_BANK_SH);
   wire wr_irq = wr_lo & (awaddr_ff == ADDR_IRQ_EN);
   wire wr_latch = wr_fire & (awaddr_ff == ADDR_PC_LATCH);
   wire wr_hit = (awaddr_ff == ADDR_WORK) || (awaddr_ff == ADDR_STATUS) || (awaddr_ff == ADDR_BANK) ||
                 (awaddr_ff == ADDR_WORK_SH) || (awaddr_ff == ADDR_STATUS_SH) ||
                 (awaddr_ff == ADDR_BANK_SH) || (awaddr_ff == ADDR_IRQ_EN) || (awaddr_ff == ADDR_PC_LATCH);

   // Next values; instruction effects win over software writes
   wire [7:0] nxt_work = ret_lit_q4 ? lit_ff :
                         restore ? work_sh_ff :
                         wr_work ? wdata_ff[7:0] : work_ff;
   wire [7:0] nxt_status = restore ? status_sh_ff : wr_status ? wdata_ff[7:0] : status_ff;
   wire [7:0] nxt_bank = restore ? bank_sh_ff : wr_bank ? wdata_ff[7:0] : bank_ff;
   wire [7:0] nxt_work_sh = i_shadow_save ? work_ff : wr_work_sh ? wdata_ff[7:0] : work_sh_ff;
   wire [7:0] nxt_status_sh = i_shadow_save ? status_ff : wr_status_sh ? wdata_ff[7:0] : status_sh_ff;
   wire [7:0] nxt_bank_sh = i_shadow_save ? bank_ff : wr_bank_sh ? wdata_ff[7:0] : bank_sh_ff;
   wire nxt_en_high = set_en_high | (wr_irq ? wdata_ff[EN_HIGH_BIT] : en_high_ff);
   wire nxt_en_low = set_en_low | (wr_irq ? wdata_ff[EN_LOW_BIT] : en_low_ff);
   wire [PC_W-1:0] nxt_pc = pop_now ? i_stack_top_value :
                            is_q4 ? pc_ff + PC_W'(2) : pc_ff;

   ////////////////////////////////////////////////////////////////////////
   // Phase counter and instruction latch
   always_ff @(posedge i_ref_clk) begin
      if (rst_all) begin
         phase_ff <= PH_Q1;
         op_ff <= OP_OTHER;
         sel_ff <= 1'b0;
         lit_ff <= BYTE_RST;
         flush_ff <= 1'b0;
      end else begin
         case (phase_ff)
            PH_Q1: phase_ff <= PH_Q2;
            PH_Q2: phase_ff <= PH_Q3;
            PH_Q3: phase_ff <= PH_Q4;
            default: phase_ff <= PH_Q1;
         endcase
         if (is_q1) begin
            op_ff <= (i_instr_valid & ~flush_ff) ? dec_op : OP_OTHER;
            sel_ff <= dec_sel;
            lit_ff <= dec_lit;
         end
         if (is_q4) begin
            flush_ff <= is_ret;
         end
      end
   end

   // Software reset pulse, one clock wide
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         soft_rst_ff <= 1'b0;
      end else begin
         soft_rst_ff <= start_reset & ~soft_rst_ff;
      end
   end

   // Core registers; program counter latches change only by software writes or reset
   always_ff @(posedge i_ref_clk) begin
      if (rst_all) begin
         pc_ff <= '0;
         work_ff <= BYTE_RST;
         status_ff <= BYTE_RST;
         bank_ff <= BYTE_RST;
         work_sh_ff <= BYTE_RST;
         status_sh_ff <= BYTE_RST;
         bank_sh_ff <= BYTE_RST;
         en_high_ff <= 1'b0;
         en_low_ff <= 1'b0;
         latch_hi_ff <= BYTE_RST;
         latch_up_ff <= '0;
      end else begin
         pc_ff <= nxt_pc;
         work_ff <= nxt_work;
         status_ff <= nxt_status;
         bank_ff <= nxt_bank;
         work_sh_ff <= nxt_work_sh;
         status_sh_ff <= nxt_status_sh;
         bank_sh_ff <= nxt_bank_sh;
         en_high_ff <= nxt_en_high;
         en_low_ff <= nxt_en_low;
         if (wr_latch & wstrb_ff[0]) begin
            latch_hi_ff <= wdata_ff[7:0];
         end
         if (wr_latch & wstrb_ff[1]) begin
            latch_up_ff <= wdata_ff[LATCH_UP_LSB+4:LATCH_UP_LSB];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data select
   wire [31:0] rd_val = (i_araddr == ADDR_WORK) ? {24'h0, work_ff} :
                        (i_araddr == ADDR_STATUS) ? {24'h0, status_ff} :
                        (i_araddr == ADDR_BANK) ? {24'h0, bank_ff} :
                        (i_araddr == ADDR_WORK_SH) ? {24'h0, work_sh_ff} :
                        (i_araddr == ADDR_STATUS_SH) ? {24'h0, status_sh_ff} :
                        (i_araddr == ADDR_BANK_SH) ? {24'h0, bank_sh_ff} :
                        (i_araddr == ADDR_IRQ_EN) ? {24'h0, en_high_ff, en_low_ff, 6'h0} :
                        (i_araddr == ADDR_PC) ? 32'(pc_ff) :
                        (i_araddr == ADDR_PC_LATCH) ? {19'h0, latch_up_ff, latch_hi_ff} :
                        (i_araddr == ADDR_EXEC) ? {27'h0, flush_ff, op_ff, phase_ff} : 32'h0;
   wire rd_hit = (i_araddr <= ADDR_EXEC) && (i_araddr[1:0] == 2'h0);

   // AXI4-Lite channel handshakes
   assign o_awready = ~aw_held_ff & ~bvalid_ff;
   assign o_wready = ~w_held_ff & ~bvalid_ff;
   assign o_arready = ~rvalid_ff;
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         bresp_ff <= RESP_OKAY;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
      end else begin
         if (i_awvalid & o_awready) begin
            aw_held_ff <= 1'b1;
            awaddr_ff <= i_awaddr;
         end
         if (i_wvalid & o_wready) begin
            w_held_ff <= 1'b1;
            wdata_ff <= i_wdata;
            wstrb_ff <= i_wstrb;
         end
         if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (i_arvalid & o_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_hit ? rd_val : 32'h0;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (i_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_stack_pop = pop_now;
   assign o_phase = phase_ff;
   assign o_soft_reset = soft_rst_ff;
   assign o_pc = pc_ff;
   assign o_work_reg = work_ff;
   assign o_status = status_ff;
   assign o_bank_select_reg = bank_ff;
   assign o_high_prio_global_irq_en = en_high_ff;
   assign o_low_prio_global_irq_en = en_low_ff;
   assign o_bvalid = bvalid_ff;
   assign o_bresp = bresp_ff;
   assign o_rvalid = rvalid_ff;
   assign o_rdata = rdata_ff;
   assign o_rresp = rresp_ff;
endmodule // ret_exec
`default_nettype wire

// File: design/ret_exec_pkg.sv
package ret_exec_pkg;
   // Instruction encodings
   localparam logic [15:0] SOFT_RESET_WORD = 16'h00FF;
   localparam logic [15:0] RET_IRQ_WORD = 16'h0010;
   localparam logic [15:0] RET_IRQ_MASK = 16'hFFFE;
   localparam logic [7:0] RET_LIT_UPPER = 8'h0C;
   // Register byte addresses
   localparam logic [7:0] ADDR_WORK = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_BANK = 8'h08;
   localparam logic [7:0] ADDR_WORK_SH = 8'h0C;
   localparam logic [7:0] ADDR_STATUS_SH = 8'h10;
   localparam logic [7:0] ADDR_BANK_SH = 8'h14;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
   localparam logic [7:0] ADDR_PC = 8'h1C;
   localparam logic [7:0] ADDR_PC_LATCH = 8'h20;
   localparam logic [7:0] ADDR_EXEC = 8'h24;
   // Field positions
   localparam int EN_HIGH_BIT = 7;
   localparam int EN_LOW_BIT = 6;
   localparam int LATCH_UP_LSB = 8;
   // Reset values and response codes
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Instruction cycle phases, Gray order
   typedef enum logic [1:0] {
      PH_Q1 = 2'h0,
      PH_Q2 = 2'h1,
      PH_Q3 = 2'h3,
      PH_Q4 = 2'h2
   } phase_t;
   // Decoded operations
   typedef enum logic [1:0] {
      OP_OTHER = 2'h0,
      OP_SOFT_RESET = 2'h1,
      OP_RET_IRQ = 2'h2,
      OP_RET_LIT = 2'h3
   } op_t;
endpackage

// File: design/ret_exec_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ret_exec_decoder (
   input wire logic [15:0] i_word,
   output ret_exec_pkg::op_t o_op,
   output logic o_shadow_sel,
   output logic [7:0] o_literal
);
   import ret_exec_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Fixed encodings
   wire is_soft_reset = (i_word == SOFT_RESET_WORD);
   wire is_ret_irq = ((i_word & RET_IRQ_MASK) == RET_IRQ_WORD);
   wire is_ret_lit = (i_word[15:8] == RET_LIT_UPPER);

   // Operation select
   assign o_op = is_soft_reset ? OP_SOFT_RESET :
                 is_ret_irq ? OP_RET_IRQ :
                 is_ret_lit ? OP_RET_LIT : OP_OTHER;
   assign o_shadow_sel = i_word[0];
   assign o_literal = i_word[7:0];
endmodule // ret_exec_decoder
`default_nettype wire

// File: verif/ret_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ret_exec_assertions
   import ret_exec_pkg::*;
#(
   parameter int PC_W = 21
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr_word,
   input wire logic [PC_W-1:0] i_stack_top_value,
   input wire logic o_stack_pop,
   input wire logic i_prio_en,
   input wire logic i_in_high_prio,
   input wire phase_t o_phase,
   input wire logic o_soft_reset,
   input wire logic [PC_W-1:0] o_pc,
   input wire logic [7:0] o_work_reg,
   input wire logic o_high_prio_global_irq_en,
   input wire logic o_low_prio_global_irq_en
);
   logic [15:0] word_ff;
   logic flush_ff;
   // Decode of the word taken now and of the word in flight
   wire take = o_phase == PH_Q1 && i_instr_valid && !flush_ff;
   wire is_lit = i_instr_word[15:8] == RET_LIT_UPPER;
   wire is_irq = (i_instr_word & RET_IRQ_MASK) == RET_IRQ_WORD;
   wire was_lit = word_ff[15:8] == RET_LIT_UPPER;
   wire was_irq = (word_ff & RET_IRQ_MASK) == RET_IRQ_WORD;
   wire [7:0] lit = word_ff[7:0];
   // Track the word in flight and the ignored slot after a return
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         word_ff <= 16'h0000;
         flush_ff <= 1'h0;
      end else begin
         if (take) word_ff <= i_instr_word;
         flush_ff <= o_stack_pop || (flush_ff && o_phase != PH_Q1);
      end
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   phase_order_a: assert property (o_phase == PH_Q1 |=> o_phase == PH_Q2)
      else $error("phase after Q1 is not Q2");
   lit_take_a: assert property (take && is_lit |-> ##3 o_stack_pop)
      else $error("literal return did not pop at Q4");
   irq_take_a: assert property (take && is_irq |-> ##3 o_stack_pop)
      else $error("interrupt return did not pop at Q4");
   rst_take_a: assert property (take && i_instr_word == SOFT_RESET_WORD |-> ##2 o_soft_reset)
      else $error("reset word did not start reset");
   pop_pc_a: assert property (o_stack_pop |=> o_pc == $past(i_stack_top_value))
      else $error("pc not loaded from stack top");
   lit_work_a: assert property (o_stack_pop && was_lit |=> o_work_reg == $past(lit))
      else $error("literal not written to work register");
   irq_en_a: assert property (o_stack_pop && was_irq |=>
      ($past(i_prio_en) && !$past(i_in_high_prio) ? o_low_prio_global_irq_en : o_high_prio_global_irq_en))
      else $error("global enable not set on return");
   rst_state_a: assert property (o_soft_reset |=> o_pc == '0 && o_work_reg == 8'h00 &&
      !o_high_prio_global_irq_en && !o_low_prio_global_irq_en && o_phase == PH_Q1)
      else $error("core state not cleared by reset word");
endmodule // ret_exec_assertions
bind ret_exec ret_exec_assertions #(.PC_W(PC_W)) i_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
   .i_instr_valid(i_instr_valid), .i_instr_word(i_instr_word), .i_stack_top_value(i_stack_top_value),
   .o_stack_pop(o_stack_pop), .i_prio_en(i_prio_en), .i_in_high_prio(i_in_high_prio), .o_phase(o_phase),
   .o_soft_reset(o_soft_reset), .o_pc(o_pc), .o_work_reg(o_work_reg),
   .o_high_prio_global_irq_en(o_high_prio_global_irq_en), .o_low_prio_global_irq_en(o_low_prio_global_irq_en));
`default_nettype wire

// File: verif/prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
   input wire logic [20:0] i_pc,
   input wire logic i_run,
   output logic o_instr_valid,
   output logic [15:0] o_instr_word
);
   logic [15:0] mem [32];
   // Word at the halfword address; an idle bus shows the inverse
   assign o_instr_valid = i_run;
   assign o_instr_word = i_run ? mem[i_pc[5:1]] : ~mem[i_pc[5:1]];
endmodule // prog_mem_model
`default_nettype wire

// File: verif/reset_and_return_instr_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module reset_and_return_instr_exec_tb_top;
   import ret_exec_pkg::*;
   logic i_ref_clk = 1'h0, i_srst = 1'h1, run = 1'h0, i_prio_en = 1'h0, i_in_high_prio = 1'h0;
   logic i_shadow_save = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
   logic i_arvalid = 1'h0, i_rready = 1'h0, i_instr_valid;
   logic [3:0] i_wstrb = 4'hF;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
   logic [15:0] i_instr_word;
   logic [20:0] i_stack_top_value = 21'h0;
   logic [31:0] i_wdata = 32'h0;
   logic o_stack_pop, o_soft_reset, o_high_prio_global_irq_en, o_low_prio_global_irq_en;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp;
   logic [7:0] o_work_reg, o_status, o_bank_select_reg;
   logic [20:0] o_pc;
   logic [31:0] o_rdata;
   phase_t o_phase;
   int n_errors = 0, n_tests = 0;
   ret_exec i_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_instr_valid(i_instr_valid),
      .i_instr_word(i_instr_word), .i_stack_top_value(i_stack_top_value), .o_stack_pop(o_stack_pop),
      .i_prio_en(i_prio_en), .i_in_high_prio(i_in_high_prio), .i_shadow_save(i_shadow_save), .o_phase(o_phase),
      .o_soft_reset(o_soft_reset), .o_pc(o_pc), .o_work_reg(o_work_reg), .o_status(o_status),
      .o_bank_select_reg(o_bank_select_reg), .o_high_prio_global_irq_en(o_high_prio_global_irq_en),
      .o_low_prio_global_irq_en(o_low_prio_global_irq_en), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
      .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
      .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));
   prog_mem_model i_mem (.i_pc(o_pc), .i_run(run), .o_instr_valid(i_instr_valid), .o_instr_word(i_instr_word));
   always #5 i_ref_clk = ~i_ref_clk;
   ////////////////////////////////////////
   task automatic chk(input string s, input logic [33:0] g, input logic [33:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask
   // One register access; q returns response and read data
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [33:0] q);
      logic a1, a2, a3, r, done;
      done = 1'h0;
      q = 34'h0;
      @(posedge i_ref_clk);
      i_awaddr <= a;
      i_araddr <= a;
      i_wdata <= d;
      i_awvalid <= w;
      i_wvalid <= w;
      i_arvalid <= !w;
      i_bready <= w; // Response ready held from the request on
      i_rready <= !w;
      repeat (30) begin
         @(negedge i_ref_clk);
         a1 = i_awvalid && o_awready;
         a2 = i_wvalid && o_wready;
         a3 = i_arvalid && o_arready;
         r = w ? (o_bvalid && i_bready) : (o_rvalid && i_rready);
         if (r) q = w ? {o_bresp, 32'h0} : {o_rresp, o_rdata};
         @(posedge i_ref_clk);
         if (a1) i_awvalid <= 1'h0;
         if (a2) i_wvalid <= 1'h0;
         if (a3) i_arvalid <= 1'h0;
         if (r) begin
            i_bready <= 1'h0;
            i_rready <= 1'h0;
            done = 1'h1;
            break;
         end
      end
      chk("axi answer", done, 34'h1);
   endtask
   // Fill memory with one word, run until it pops or resets
   task automatic go(input logic [15:0] w, input logic [20:0] top);
      int k;
      logic rs;
      for (k = 0; k < 32; k++) i_mem.mem[k] = w;
      @(posedge i_ref_clk);
      i_stack_top_value <= top;
      run <= 1'h1;
      k = 0;
      do begin
         @(negedge i_ref_clk);
         k++;
      end while (o_stack_pop !== 1'h1 && o_soft_reset !== 1'h1 && k < 40);
      chk("event", k < 40, 34'h1);
      rs = o_soft_reset === 1'h1;
      @(posedge i_ref_clk);
      if (rs) run <= 1'h0;
      @(negedge i_ref_clk);
   endtask
   // Word in the slot after a return must be ignored
   task automatic flush_chk;
      int k;
      @(posedge i_ref_clk);
      run <= 1'h0;
      k = 0;
      repeat (8) begin
         @(negedge i_ref_clk);
         k += o_stack_pop;
      end
      chk("flush", k, 34'h0);
   endtask
   task automatic t_lit;
      logic [33:0] q;
      axi(1'h1, ADDR_PC_LATCH, 32'h1F34, q);
      chk("latch bresp", q, {RESP_OKAY, 32'h0});
      go(16'h0C5A, 21'h10);
      chk("pc", o_pc, 34'h10);
      chk("work", o_work_reg, 34'h5A);
      flush_chk;
      axi(1'h0, ADDR_PC_LATCH, 32'h0, q);
      chk("latch", q, 34'h1F34);
      $display("test lit done");
   endtask
   task automatic t_irq;
      logic [33:0] q;
      axi(1'h1, ADDR_WORK, 32'h11, q);
      axi(1'h1, ADDR_STATUS, 32'h22, q);
      axi(1'h1, ADDR_BANK, 32'h33, q);
      i_shadow_save <= 1'h1;
      i_prio_en <= 1'h1;
      @(posedge i_ref_clk);
      i_shadow_save <= 1'h0;
      axi(1'h1, ADDR_WORK, 32'h99, q);
      go(16'h0011, 21'h20);
      chk("pc1", o_pc, 34'h20);
      chk("restore", {o_work_reg, o_status, o_bank_select_reg}, 34'h112233);
      chk("en1", {o_high_prio_global_irq_en, o_low_prio_global_irq_en}, 34'h1);
      flush_chk;
      axi(1'h1, ADDR_WORK, 32'h44, q);
      axi(1'h1, ADDR_IRQ_EN, 32'h0, q);
      chk("en bresp", q, {RESP_OKAY, 32'h0});
      i_in_high_prio <= 1'h1;
      go(16'h0010, 21'h30);
      chk("pc2", o_pc, 34'h30);
      chk("keep", o_work_reg, 34'h44);
      chk("en2", {o_high_prio_global_irq_en, o_low_prio_global_irq_en}, 34'h2);
      flush_chk;
      axi(1'h1, ADDR_IRQ_EN, 32'h0, q);
      i_prio_en <= 1'h0;
      i_in_high_prio <= 1'h0;
      go(16'h0010, 21'h40);
      chk("pc3", o_pc, 34'h40);
      chk("en3", {o_high_prio_global_irq_en, o_low_prio_global_irq_en}, 34'h2);
      flush_chk;
      $display("test irq done");
   endtask
   task automatic t_rst;
      logic [33:0] q;
      go(16'h00FF, 21'h0);
      chk("core", {o_pc[7:0], o_work_reg, o_status, o_bank_select_reg, o_high_prio_global_irq_en,
         o_low_prio_global_irq_en}, 34'h0);
      axi(1'h0, ADDR_WORK_SH, 32'h0, q);
      chk("shadow", q, 34'h0);
      axi(1'h0, 8'h30, 32'h0, q);
      chk("unmapped", q, {RESP_SLVERR, 32'h0});
      axi(1'h1, ADDR_PC, 32'h0, q);
      chk("ro write", q, {RESP_SLVERR, 32'h0});
      $display("test rst done");
   endtask
   task automatic close_out;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence after reset
   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_srst <= 1'h0;
      t_lit;
      t_irq;
      t_rst;
      close_out;
   end
   // Watchdog against a hang
   initial begin
      #20000;
      n_errors++;
      close_out;
   end
endmodule // reset_and_return_instr_exec_tb_top
`default_nettype wire
